// ===== verilog/pmcs_pkg.sv
package pmcs_pkg;
  // Register port address width
  localparam int ADDR_W = 10;
  // Register addresses
  localparam logic [9:0] ADDR_MISC = 10'h3c2;
  localparam logic [9:0] ADDR_NUM0 = 10'h300;
  localparam logic [9:0] ADDR_NUM1 = 10'h301;
  localparam logic [9:0] ADDR_NUM2 = 10'h302;
  localparam logic [9:0] ADDR_NUM3 = 10'h303;
  localparam logic [9:0] ADDR_DEN0 = 10'h304;
  localparam logic [9:0] ADDR_DEN1 = 10'h305;
  localparam logic [9:0] ADDR_DEN2 = 10'h306;
  localparam logic [9:0] ADDR_DEN3 = 10'h307;
  localparam logic [9:0] ADDR_MEMCLK = 10'h308;
  localparam logic [9:0] ADDR_PM = 10'h309;
  localparam logic [9:0] ADDR_STATUS = 10'h30a;
  // Field positions
  localparam int MISC_SEL_LO = 2;
  localparam int MISC_SEL_HI = 3;
  localparam int NUM_MSB = 6;
  localparam int DEN_LSB = 1;
  localparam int DEN_MSB = 7;
  localparam int DEN_POST_BIT = 0;
  localparam int MEM_MULT_MSB = 5;
  localparam int MEM_USE_MCLK_BIT = 6;
  localparam int PM_SYS_BIT = 4;
  localparam int PM_STATIC_CLK_BIT = 3;
  localparam int PM_VSYNC_BIT = 2;
  localparam int PM_HSYNC_BIT = 1;
  // Reset values
  localparam logic [7:0] RST_MISC = 8'h00;
  localparam logic [7:0] RST_NUM = 8'h00;
  localparam logic [7:0] RST_DEN = 8'h00;
  localparam logic [7:0] RST_MEMCLK = 8'h00;
  localparam logic [7:0] RST_PM = 8'h00;
  // Break-before-make gap between clock sources
  localparam int CLK_PERIOD_NS = 40;
  localparam int HOLD_TIME_NS = 200;
  localparam int HOLD_CYCLES =
    (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Clock source codes driven to the clock multiplexers
  typedef enum logic [2:0] {
    SRC_OFF = 3'h0,
    SRC_SYNTH = 3'h1,
    SRC_MCLK_DIV2 = 3'h2,
    SRC_MCLK = 3'h3,
    SRC_DOT = 3'h6
  } pmcs_src_type;
  // Switch sequencer, Gray coded along run-hold-load
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HOLD = 2'b01,
    ST_LOAD = 2'b11
  } pmcs_state_type;
endpackage : pmcs_pkg

// ===== verilog/pmcs_clock_select.sv
// Notes on behaviour
// RULE1 - Provide pixel clock and memory clock controls
// RULE2 - Misc select bits choose one of four pairs
// RULE3 - Select 00..11 maps to pairs zero..three
// RULE4 - Numerator is low seven bits
// RULE5 - Denominator bits 7:1, postscaler bit 0
// RULE6 - Postscaler bit set halves pixel frequency
// RULE7 - Pixel frequency is ref times num over den
// RULE8 - Enable pin high: both from selected pair
// RULE9 - Enable pin low: timing from dot pin
// RULE10 - Memory-clock bit replaces synth, pair-three halves
// RULE11 - Memory clock multiplier is bits 5:0
// RULE12 - Software halves clock above 85 MHz
// RULE13 - Software picks mid-range numerator and denominator
// RULE14 - Software uses memory clock when too close
// RULE15 - Four power-management bits, positions four to one
// RULE16 - Static sync bit also powers down DAC
// RULE17 - Memory refresh never stops
// RULE18 - Pass-through source drives enable pin low
// RULE19 - Switch sources without runt pulses
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module pmcs_clock_select
  import pmcs_pkg::*;
#(
  parameter int HOLD_CNT = HOLD_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic ext_dot_clock_enable_pin_i,
  output logic pixel_synth_enable_o,
  output logic [6:0] pix_num_o,
  output logic [6:0] pix_den_o,
  output logic pix_post_o,
  output logic [5:0] mem_mult_o,
  output logic [2:0] dac_src_o,
  output logic [2:0] crt_src_o,
  output logic system_pm_o,
  output logic static_clock_o,
  output logic static_vsync_o,
  output logic static_hsync_o,
  output logic dac_power_down_o,
  output logic refresh_enable_o
);

  // Gap counter is eight bits wide
  if (HOLD_CNT < 1 || HOLD_CNT > 255) begin : g_bad_hold
    $error("HOLD_CNT must lie in 1..255");
  end

  // Decide the source for one clock consumer
  function automatic pmcs_src_type pick_src(input logic dot_en,
                                            input logic use_mclk,
                                            input logic half,
                                            input logic sel_hi,
                                            input logic is_dac);
    pmcs_src_type src;
    if (dot_en) begin
      src = SRC_SYNTH; // [RULE8]
    end else if (!is_dac || sel_hi) begin
      src = SRC_DOT; // [RULE9]
    end else begin
      src = SRC_SYNTH;
    end
    if (use_mclk && src == SRC_SYNTH) begin
      src = half ? SRC_MCLK_DIV2 : SRC_MCLK; // [RULE10]
    end
    return src;
  endfunction : pick_src

  // Software registers
  logic [7:0] misc; // Pair select lives in bits 3:2
  logic [7:0] num [4]; // Pixel numerators
  logic [7:0] den [4]; // Pixel denominators with postscaler
  logic [7:0] mem_ctl; // Memory clock control
  logic [7:0] pm_ctl; // Power management control

  // Enable pin synchroniser, three stages
  logic dot_s1;
  logic dot_s2;
  logic dot_s3;
  logic dot_en; // Filtered pin level

  // Switch sequencer
  pmcs_state_type state;
  pmcs_state_type next_state;
  logic [7:0] hold_cnt; // Cycles left in the gap
  logic [7:0] next_hold_cnt;
  logic [2:0] next_dac_src;
  logic [2:0] next_crt_src;

  // Decode of write strobes
  wire wr_misc = wr_i && addr_i == ADDR_MISC;
  wire wr_mem = wr_i && addr_i == ADDR_MEMCLK;
  wire wr_pm = wr_i && addr_i == ADDR_PM;
  wire wr_num = wr_i && addr_i[ADDR_W-1:2] == ADDR_NUM0[ADDR_W-1:2];
  wire wr_den = wr_i && addr_i[ADDR_W-1:2] == ADDR_DEN0[ADDR_W-1:2];
  wire [1:0] wr_idx = addr_i[1:0];

  // Active pair selected by the misc bits
  wire [1:0] pair_sel = misc[MISC_SEL_HI:MISC_SEL_LO]; // [RULE2]
  wire [7:0] num_sel = num[pair_sel]; // [RULE3]
  wire [7:0] den_sel = den[pair_sel]; // [RULE3]
  wire use_mclk = mem_ctl[MEM_USE_MCLK_BIT];
  wire mclk_half = den[3][DEN_POST_BIT]; // [RULE10]

  // Target sources for both consumers
  wire [2:0] dac_target = pick_src(dot_en, use_mclk, mclk_half,
                                   pair_sel[1], 1'b1);
  wire [2:0] crt_target = pick_src(dot_en, use_mclk, mclk_half,
                                   pair_sel[1], 1'b0);
  wire target_moved = dac_target != dac_src_o ||
                      crt_target != crt_src_o;
  wire busy = state != ST_RUN;

  // Static sync also powers the DAC down
  wire next_dac_pd = pm_ctl[PM_VSYNC_BIT] ||
                     pm_ctl[PM_HSYNC_BIT]; // [RULE16]

  // Read mux, unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (addr_i)
      ADDR_MISC: rd_mux = misc;
      ADDR_NUM0, ADDR_NUM1, ADDR_NUM2, ADDR_NUM3: rd_mux = num[wr_idx];
      ADDR_DEN0, ADDR_DEN1, ADDR_DEN2, ADDR_DEN3: rd_mux = den[wr_idx];
      ADDR_MEMCLK: rd_mux = mem_ctl;
      ADDR_PM: rd_mux = pm_ctl;
      ADDR_STATUS: rd_mux = {busy, dot_en, crt_src_o, dac_src_o};
      default: rd_mux = 8'h00;
    endcase
  end

  // Register file writes
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      misc <= RST_MISC;
      mem_ctl <= RST_MEMCLK;
      pm_ctl <= RST_PM;
      for (int i = 0; i < 4; i++) begin
        num[i] <= RST_NUM;
        den[i] <= RST_DEN;
      end
    end else begin
      if (wr_misc) begin
        misc <= wdata_i;
      end
      if (wr_mem) begin
        mem_ctl <= wdata_i;
      end
      if (wr_pm) begin
        pm_ctl <= wdata_i; // [RULE15]
      end
      if (wr_num) begin
        num[wr_idx] <= wdata_i;
      end
      if (wr_den) begin
        den[wr_idx] <= wdata_i;
      end
    end
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rd_i ? rd_mux : 8'h00;
    end
  end

  // Pin synchroniser; only agreeing later stages update the level
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dot_s1 <= 1'b1;
      dot_s2 <= 1'b1;
      dot_s3 <= 1'b1;
      dot_en <= 1'b1;
    end else begin
      dot_s1 <= ext_dot_clock_enable_pin_i;
      dot_s2 <= dot_s1;
      dot_s3 <= dot_s2;
      if (dot_s2 == dot_s3) begin
        dot_en <= dot_s3;
      end
    end
  end

  // Break-before-make: park both muxes low, wait, then load
  always_comb begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    next_dac_src = dac_src_o;
    next_crt_src = crt_src_o;
    case (state)
      ST_RUN: begin
        if (target_moved) begin
          next_state = ST_HOLD; // [RULE19]
          next_hold_cnt = 8'(HOLD_CNT - 1);
          next_dac_src = SRC_OFF;
          next_crt_src = SRC_OFF;
        end
      end
      ST_HOLD: begin
        // Outgoing clock held low for the whole gap
        if (hold_cnt == 8'h00) begin
          next_state = ST_LOAD;
        end else begin
          next_hold_cnt = hold_cnt - 8'h01;
        end
      end
      ST_LOAD: begin
        // Targets sampled late, so a change during the gap lands here
        next_state = ST_RUN;
        next_dac_src = dac_target;
        next_crt_src = crt_target;
      end
      default: begin
        next_state = ST_RUN;
        next_dac_src = SRC_OFF;
        next_crt_src = SRC_OFF;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_RUN;
      hold_cnt <= 8'h00;
      dac_src_o <= SRC_OFF;
      crt_src_o <= SRC_OFF;
    end else begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      dac_src_o <= next_dac_src;
      crt_src_o <= next_crt_src;
    end
  end

  // Synthesizer settings and power controls, all registered
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pixel_synth_enable_o <= 1'b1;
      pix_num_o <= 7'h00;
      pix_den_o <= 7'h00;
      pix_post_o <= 1'b0;
      mem_mult_o <= 6'h00;
      system_pm_o <= 1'b0;
      static_clock_o <= 1'b0;
      static_vsync_o <= 1'b0;
      static_hsync_o <= 1'b0;
      dac_power_down_o <= 1'b0;
      refresh_enable_o <= 1'b1;
    end else begin
      pixel_synth_enable_o <= !use_mclk; // [RULE1] [RULE10]
      pix_num_o <= num_sel[NUM_MSB:0]; // [RULE4] [RULE7]
      pix_den_o <= den_sel[DEN_MSB:DEN_LSB]; // [RULE5] [RULE7]
      pix_post_o <= den_sel[DEN_POST_BIT]; // [RULE6]
      mem_mult_o <= mem_ctl[MEM_MULT_MSB:0]; // [RULE1] [RULE11]
      system_pm_o <= pm_ctl[PM_SYS_BIT]; // [RULE15]
      static_clock_o <= pm_ctl[PM_STATIC_CLK_BIT]; // [RULE15]
      static_vsync_o <= pm_ctl[PM_VSYNC_BIT]; // [RULE15]
      static_hsync_o <= pm_ctl[PM_HSYNC_BIT]; // [RULE15]
      dac_power_down_o <= next_dac_pd; // [RULE16]
      refresh_enable_o <= 1'b1; // No power bit may stop refresh [RULE17]
    end
  end

  // Checks, all on the one clock
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // Gap sequence: both muxes parked through the whole hold
  // The count matches the default gap only; revisit with HOLD_CNT
  sequence s_parked;
    (dac_src_o == SRC_OFF && crt_src_o == SRC_OFF &&
     state == ST_HOLD)[*5];
  endsequence

  // Load keeps the muxes parked one more edge, then run resumes
  sequence s_reload;
    (state == ST_LOAD && dac_src_o == SRC_OFF) ##1 state == ST_RUN;
  endsequence

  sequence s_start_switch;
    state == ST_RUN && target_moved;
  endsequence

  a_pair_num_map: assert property ( // [RULE3]
    ##1 pix_num_o == $past(num[misc[MISC_SEL_HI:MISC_SEL_LO]][6:0]))
    else $error("Numerator not taken from selected pair");

  a_den_post_split: assert property ( // [RULE5]
    ##1 pix_den_o == $past(den_sel[7:1]) &&
        pix_post_o == $past(den_sel[0]))
    else $error("Denominator or postscaler field misplaced");

  a_synth_shutdown: assert property ( // [RULE10]
    mem_ctl[6] |=> !pixel_synth_enable_o)
    else $error("Pixel synth left running in memory clock mode");

  a_mult_field: assert property ( // [RULE11]
    wr_mem ##1 1'b1 |=> mem_mult_o == $past(wdata_i, 2) % 64)
    else $error("Memory clock multiplier wrong");

  a_static_dac_off: assert property ( // [RULE16]
    (static_vsync_o || static_hsync_o) |-> dac_power_down_o)
    else $error("Static sync without DAC power down");

  a_refresh_kept: assert property ( // [RULE17]
    wr_pm |=> ##1 refresh_enable_o)
    else $error("Refresh stopped by power management");

  a_no_direct_swap: assert property ( // [RULE19]
    $past(dac_src_o) != SRC_OFF && dac_src_o != $past(dac_src_o)
      |-> dac_src_o == SRC_OFF)
    else $error("Pixel clock swapped without a low gap");

  a_gap_then_run: assert property ( // [RULE19]
    s_start_switch |=> s_parked ##1 s_reload)
    else $error("Switch gap length or order wrong");

  a_crt_dot_pin: assert property ( // [RULE9]
    state == ST_LOAD && !dot_en |=> crt_src_o == SRC_DOT)
    else $error("Timing clock not from dot pin");

  a_synth_pair: assert property ( // [RULE8]
    state == ST_LOAD && dot_en && !use_mclk
      |=> dac_src_o == SRC_SYNTH && crt_src_o == SRC_SYNTH)
    else $error("Synth not chosen with enable pin high");

  a_read_latency: assert property ( // [RULE2]
    rd_i && addr_i == ADDR_MISC && !$past(wr_misc) && !wr_misc
      |=> rdata_o == misc)
    else $error("Misc read data wrong");

  // Each power bit reaches its output two edges after the write
  a_pm_fields: assert property ( // [RULE15]
    wr_pm ##1 1'b1 |=>
      {3'h0, system_pm_o, static_clock_o, static_vsync_o,
       static_hsync_o, 1'b0} == ($past(wdata_i, 2) & 8'h1e))
    else $error("Power bit copied to the wrong output");

  // Synth runs whenever the memory clock is not substituted
  a_synth_running: assert property ( // [RULE1]
    !use_mclk |=> pixel_synth_enable_o)
    else $error("Pixel synth stopped without memory clock mode");

  // Upper select bit with the pin low hands the DAC to the pin too
  a_dac_dot_pin: assert property ( // [RULE9]
    state == ST_LOAD && !dot_en && pair_sel[1]
      |=> dac_src_o == SRC_DOT)
    else $error("DAC clock not from dot pin");

  // Lower selects keep the DAC on the pair while timing leaves
  a_dac_keeps_pair: assert property ( // [RULE9]
    state == ST_LOAD && !dot_en && !pair_sel[1] && !use_mclk
      |=> dac_src_o == SRC_SYNTH)
    else $error("DAC clock left the pair with lower select");

  // Pair-three postscaler bit halves a substituted memory clock
  a_mclk_halved: assert property ( // [RULE10]
    state == ST_LOAD && dot_en && use_mclk && mclk_half
      |=> dac_src_o == SRC_MCLK_DIV2 && crt_src_o == SRC_MCLK_DIV2)
    else $error("Memory clock not halved for the pixel clock");

endmodule : pmcs_clock_select

// ===== tb/pmcs_clock_select_tb.sv
`timescale 1ns/1ps
module pmcs_clock_select_tb;
  import pmcs_pkg::*;
  logic clk_i = 1'b0; // 25 MHz system clock
  logic nrst_i = 1'b0; // Active-low reset
  logic [ADDR_W-1:0] addr_i = '0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic pin_i = 1'b1; // Dot-clock enable pin
  logic [7:0] rdata_o;
  logic syn_en, post, spm, sclk, svs, shs, dpd, rfr;
  logic [6:0] num, den;
  logic [5:0] mult;
  logic [2:0] dac, crt;
  int n_fail = 0;
  int checks_done = 0;
  logic [ADDR_W-1:0] regs [11] = '{ADDR_MISC, ADDR_NUM0, ADDR_NUM1,
    ADDR_NUM2, ADDR_NUM3, ADDR_DEN0, ADDR_DEN1, ADDR_DEN2, ADDR_DEN3,
    ADDR_MEMCLK, ADDR_PM};
  logic [7:0] pm_vals [6] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h1e, 8'h00};

  pmcs_clock_select dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext_dot_clock_enable_pin_i(pin_i), .pixel_synth_enable_o(syn_en),
    .pix_num_o(num), .pix_den_o(den), .pix_post_o(post),
    .mem_mult_o(mult), .dac_src_o(dac), .crt_src_o(crt),
    .system_pm_o(spm), .static_clock_o(sclk), .static_vsync_o(svs),
    .static_hsync_o(shs), .dac_power_down_o(dpd), .refresh_enable_o(rfr));

  // Half-period toggle, 40 ns period
  always #20 clk_i = ~clk_i;

  // Verdict in one place for both normal end and watchdog
  task automatic tally_and_finish;
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Register and field values
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  // Clock source codes
  task automatic chk_src(input logic [2:0] got, input pmcs_src_type exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t source %h expected %h", $time, got, exp);
    end
  endtask : chk_src

  // One-cycle write strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask : rd

  // Outputs lag a write by one more edge
  task automatic settle;
    repeat (2) @(negedge clk_i);
  endtask : settle

  // Bounded wait for new sources; notes whether a dead gap was seen
  task automatic wait_src(input pmcs_src_type ed, input pmcs_src_type ec,
                          input logic gap);
    int n;
    logic off;
    n = 0;
    off = 1'b0;
    while (n < 40 && !(dac === ed && crt === ec)) begin
      @(negedge clk_i);
      if (dac === SRC_OFF && crt === SRC_OFF) off = 1'b1;
      n++;
    end
    chk_src(dac, ed);
    chk_src(crt, ec);
    chk_val({7'h0, off}, {7'h0, gap});
  endtask : wait_src

  // Main sequence
  initial begin
    logic [7:0] d, nv, dv;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    settle();
    chk_val({7'h0, rfr}, 8'h01);
    for (int i = 0; i < 11; i++) begin
      rd(regs[i], d);
      chk_val(d, 8'h00);
    end
    // Every register holds what was written; unmapped place reads 0
    for (int i = 0; i < 11; i++) begin
      wr(regs[i], 8'h11 * i[7:0] + 8'h01);
      rd(regs[i], d);
      chk_val(d, 8'h11 * i[7:0] + 8'h01);
    end
    wr(10'h3ff, 8'h5a);
    rd(10'h3ff, d);
    chk_val(d, 8'h00);
    wr(ADDR_MEMCLK, 8'h1c);
    wr(ADDR_MISC, 8'h00);
    // Each pair feeds the synthesizer; bit 7 of numerator dropped
    for (int p = 0; p < 4; p++) begin
      nv = 8'hc0 + p[7:0];
      dv = 8'h80 + 8'(p * 10) + 8'(p % 2);
      wr(ADDR_NUM0 + p[ADDR_W-1:0], nv);
      wr(ADDR_DEN0 + p[ADDR_W-1:0], dv);
      wr(ADDR_MISC, {4'h0, p[1:0], 2'b00});
      settle();
      chk_val({1'b0, num}, {1'b0, nv[6:0]});
      chk_val({1'b0, den}, {1'b0, dv[7:1]});
      chk_val({7'h0, post}, {7'h0, dv[0]});
      wait_src(SRC_SYNTH, SRC_SYNTH, 1'b0);
    end
    chk_val({2'b00, mult}, 8'h1c);
    // Pair three at half the target rate for a doubled high-rate mode
    wr(ADDR_DEN3, 8'h81);
    settle();
    chk_val({7'h0, post}, 8'h01);
    chk_val({1'b0, den}, 8'h40);
    // Memory clock replaces synth, pair-three bit 0 halves it
    wr(ADDR_DEN3, 8'h40);
    wr(ADDR_MEMCLK, 8'h5c);
    settle();
    chk_val({7'h0, syn_en}, 8'h00);
    wait_src(SRC_MCLK, SRC_MCLK, 1'b1);
    wr(ADDR_DEN3, 8'h41);
    wait_src(SRC_MCLK_DIV2, SRC_MCLK_DIV2, 1'b1);
    // Pin low: timing from dot pin, DAC too when upper select set
    @(posedge clk_i);
    pin_i <= 1'b0;
    wr(ADDR_MISC, 8'h04);
    wait_src(SRC_MCLK_DIV2, SRC_DOT, 1'b1);
    wr(ADDR_MEMCLK, 8'h1c);
    wait_src(SRC_SYNTH, SRC_DOT, 1'b1);
    wr(ADDR_MISC, 8'h08);
    wait_src(SRC_DOT, SRC_DOT, 1'b1);
    @(posedge clk_i);
    pin_i <= 1'b1;
    wr(ADDR_MISC, 8'h00);
    wait_src(SRC_SYNTH, SRC_SYNTH, 1'b1);
    chk_val({7'h0, syn_en}, 8'h01);
    // Status: idle, pin high, both consumers on the synth
    rd(ADDR_STATUS, d);
    chk_val(d, 8'h49);
    // Power bits, DAC power-down, refresh kept
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_PM, pm_vals[i]);
      settle();
      chk_val({3'h0, spm, sclk, svs, shs, 1'b0},
              pm_vals[i] & 8'h1e);
      chk_val({7'h0, dpd}, {7'h0, |pm_vals[i][2:1]});
      chk_val({7'h0, rfr}, 8'h01);
    end
    tally_and_finish();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #400us;
    n_fail++;
    tally_and_finish();
  end
endmodule : pmcs_clock_select_tb
